// File: src/intcg_pkg.sv
package intcg_pkg;

  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned CLK_MHZ           = 40;

  localparam int unsigned ADDR_W            = 3;
  localparam int unsigned DATA_W            = 8;
  localparam logic [2:0]  ADDR_CTRL1        = 3'h0;
  localparam logic [2:0]  ADDR_CTRL2        = 3'h1;
  localparam logic [2:0]  ADDR_STATUS       = 3'h2;
  localparam logic [2:0]  ADDR_FILTER       = 3'h3;
  localparam logic [2:0]  ADDR_TRIM         = 3'h4;

  localparam logic [7:0]  CTRL1_RST         = 8'h00;
  localparam logic [7:0]  CTRL2_RST         = 8'h00;
  localparam logic [7:0]  FILTER_RST        = 8'h40;
  localparam logic [7:0]  TRIM_RST          = 8'h80;

  localparam int unsigned ST_LOC_BIT        = 4;
  localparam int unsigned ST_LOCK_BIT       = 3;
  localparam int unsigned ST_LOL_BIT        = 2;
  localparam int unsigned ST_READY_BIT      = 1;
  localparam int unsigned ST_REQ_BIT        = 0;

  localparam int unsigned DBG_HZ            = 8_000_000;
  localparam int unsigned DBG_DIV           = CLK_HZ / DBG_HZ;
  localparam int unsigned INT_REF_HZ        = 243_000;
  localparam logic [8:0]  INT_REF_BASE      = 9'(CLK_HZ / INT_REF_HZ);
  localparam logic [8:0]  TRIM_CENTER       = 9'h080;
  localparam int unsigned RTI_HZ            = 1_000;

  localparam int unsigned REF_TIMEOUT_NS    = 10_000;
  localparam logic [8:0]  REF_TIMEOUT_CYC   = 9'((REF_TIMEOUT_NS * CLK_MHZ) / 1000);

  localparam logic [7:0]  LOCK_TOL          = 8'h02;
  localparam logic [7:0]  UNLOCK_TOL        = 8'h08;
  localparam logic [2:0]  LOCK_RUNS         = 3'h4;
  localparam logic [7:0]  TARGET_STEP_BASE  = 8'h10;

  typedef enum logic [1:0] {
    self_clocked_mode         = 2'b00,
    loop_internal_mode        = 2'b01,
    loop_bypass_external_mode = 2'b10,
    loop_external_mode        = 2'b11
  } intcg_mode_type;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_SCM      = 3'b001,
    ST_INT_UNLK = 3'b010,
    ST_INT_LOCK = 3'b011,
    ST_BYP      = 3'b100,
    ST_EXT_UNLK = 3'b101,
    ST_EXT_LOCK = 3'b110
  } intcg_state_type;

  typedef struct packed {
    logic           high_gain_select;
    logic           range_high;
    logic           reference_type_select;
    intcg_mode_type clock_mode_field;
    logic           spare;
    logic           loc_disable;
    logic           spare0;
  } intcg_ctrl1_type;

  typedef struct packed {
    logic           lol_reset_en;
    logic [2:0]     multiplier;
    logic           loc_reset_en;
    logic [2:0]     bus_div;
  } intcg_ctrl2_type;

endpackage

// File: src/intcg_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module intcg_sync3 (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_async,
  output var  logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Level moves only once the two late stages agree
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        o_level <= s3_q;
    end
  end
endmodule // intcg_sync3
`default_nettype wire

// File: src/intcg_pow2_div.sv
`timescale 1ns/1ps
`default_nettype none
module intcg_pow2_div #(
  parameter int unsigned WIDTH = 7
) (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_tick,
  input  wire logic [2:0] i_sel,
  output var  logic       o_pulse
);
  logic [WIDTH-1:0] cnt_q;
  wire  [WIDTH-1:0] mask;
  wire              hit;

  assign mask = WIDTH'((32'h1 << i_sel) - 32'h1);
  assign hit  = (cnt_q & mask) == mask;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q   <= '0;
      o_pulse <= 1'b0;
    end
    else
    begin
      o_pulse <= i_tick && hit;
      if (i_tick)
        cnt_q <= cnt_q + WIDTH'(1);
    end
  end
endmodule // intcg_pow2_div
`default_nettype wire

// File: src/intcg_clock_generator.sv
// How it works
// - Reset always lands in self-clocked operation
// - Self-clocked: loop open, oscillator follows filter
// - Stop input freezes generator output clock
// - Internal loop mode: unlocked then locked multiple
// - External loop mode: unlocked then locked multiple
// - Bypass mode drives clock from external reference
// - Status shows lock and loss of lock
// - Status shows external reference running
// - Clock or lock loss: reset or interrupt
// - Bus divider: eight powers of two, 1..128
// - Loop output range, bus below half
// - Oscillator setting survives stop
// - Oscillator holds frequency when reference lost
// - Non-running sources cannot be selected
// - Locked loop feeds clock without software
// - First control write reserves oscillator pins when it selects an external mode
// - Low power by default, high gain optional
// - Two crystal ranges or square wave
// - About 8 MHz debug controller clock
// - Trimmable 243 kHz internal reference
// - Fixed-frequency enable output
// - Independent self-clocked real-time interrupt source
// - Two-bit mode field encoding
// - Bypass waits for reference ready
// - Internal first write locks out external modes
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module intcg_clock_generator
  import intcg_pkg::*;
#(
  parameter int unsigned RTI_DIV = CLK_HZ / RTI_HZ
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output var  logic [DATA_W-1:0] o_rd_data,
  input  wire logic              i_stop,
  input  wire logic              i_osc_in,
  output var  logic              o_osc_out,
  output var  logic              o_osc_out_oe_n,
  output var  logic              o_osc_in_en,
  output var  logic              o_high_gain,
  output var  logic              o_range_high,
  output var  logic              o_gen_clk,
  output var  logic              o_loop_clk_en,
  output var  logic              o_bus_clk_en,
  output var  logic              o_debug_local_clock_en,
  output var  logic              o_rti_clk_en,
  output var  logic              o_fixed_frequency_enable,
  output var  logic              o_locked,
  output var  logic              o_ext_ref_ready,
  output var  logic              o_reset_req,
  output var  logic              o_irq_req
);

  function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic intcg_state_type entry_state(input intcg_mode_type m, input logic ready);
    case (m)
      loop_internal_mode:        entry_state = ST_INT_UNLK;
      loop_bypass_external_mode: entry_state = ready ? ST_BYP : ST_SCM;
      loop_external_mode:        entry_state = ready ? ST_EXT_UNLK : ST_SCM;
      default:                   entry_state = ST_SCM;
    endcase
  endfunction

  function automatic intcg_mode_type state_mode(input intcg_state_type s);
    case (s)
      ST_INT_UNLK, ST_INT_LOCK: state_mode = loop_internal_mode;
      ST_BYP:                   state_mode = loop_bypass_external_mode;
      ST_EXT_UNLK, ST_EXT_LOCK: state_mode = loop_external_mode;
      default:                  state_mode = self_clocked_mode;
    endcase
  endfunction

  intcg_ctrl1_type ctrl1_q;
  intcg_ctrl1_type ctrl1_d;
  intcg_ctrl2_type ctrl2_q;
  intcg_state_type state_q;
  intcg_state_type state_d;
  logic            first_done_q;
  logic            pin_reserved_q;
  logic [7:0]      filter_q;
  logic [7:0]      trim_q;
  logic            loc_flag_q;
  logic            lol_flag_q;
  logic [7:0]      acc_q;
  logic [8:0]      ref_to_q;
  logic            ref_ready_q;
  logic            pin_prev_q;
  logic [8:0]      iref_cnt_q;
  logic [2:0]      dbg_cnt_q;
  logic [31:0]     rti_cnt_q;
  logic [7:0]      win_cnt_q;
  logic [2:0]      lock_run_q;
  logic            sel_ext_q;

  wire             pin_level;
  wire             wr_ctrl1;
  wire             wr_ctrl2;
  wire             wr_status;
  wire             wr_filter;
  wire             wr_trim;
  intcg_ctrl1_type wr_ctrl1_val;
  wire [8:0]       acc_sum;
  wire             dco_tick;
  wire             ext_tick;
  wire [8:0]       iref_period;
  wire             iref_tick;
  wire             ext_mode;
  wire             loop_state;
  wire             ref_tick;
  wire [7:0]       target;
  wire [7:0]       err;
  wire             lock_ok;
  wire             lock_lost;
  wire             loc_event;
  wire             lol_event;
  wire             src_tick;
  wire             gen_rise;
  wire             want_ext;
  logic [7:0]      rd_mux;

  intcg_sync3 u_pin_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async (i_osc_in),
    .o_level (pin_level)
  );

  assign wr_ctrl1     = i_wr && (i_addr == ADDR_CTRL1);
  assign wr_ctrl2     = i_wr && (i_addr == ADDR_CTRL2);
  assign wr_status    = i_wr && (i_addr == ADDR_STATUS);
  assign wr_filter    = i_wr && (i_addr == ADDR_FILTER);
  assign wr_trim      = i_wr && (i_addr == ADDR_TRIM);
  assign wr_ctrl1_val = intcg_ctrl1_type'(i_wr_data);

  // Write-once fields settle on the first write; the pin claim rides on it
  always_comb
  begin
    ctrl1_d = ctrl1_q;
    if (wr_ctrl1 && !first_done_q)
      ctrl1_d = wr_ctrl1_val;
    else if (wr_ctrl1)
    begin
      if (pin_reserved_q || !wr_ctrl1_val.clock_mode_field[1])
        ctrl1_d.clock_mode_field = wr_ctrl1_val.clock_mode_field;
      ctrl1_d.loc_disable = wr_ctrl1_val.loc_disable;
    end
  end

  // Phase accumulator stands in for the controlled oscillator
  assign acc_sum  = {1'b0, acc_q} + {1'b0, filter_q};
  assign dco_tick = acc_sum[8];
  assign ext_tick = pin_level && !pin_prev_q && pin_reserved_q;

  // Trim moves the reference period around its nominal count
  assign iref_period = INT_REF_BASE + {1'b0, trim_q} - TRIM_CENTER;
  assign iref_tick   = (iref_cnt_q >= iref_period - 9'h001);

  assign ext_mode   = (state_q == ST_BYP) || (state_q == ST_EXT_UNLK) || (state_q == ST_EXT_LOCK);
  assign loop_state = (state_q == ST_INT_UNLK) || (state_q == ST_INT_LOCK) ||
                      (state_q == ST_EXT_UNLK) || (state_q == ST_EXT_LOCK);
  // A lost reference gives no ticks, so the oscillator word stays put
  assign ref_tick   = loop_state && (ext_mode ? ext_tick : iref_tick);
  assign target     = {ctrl2_q.multiplier, 4'h0} + TARGET_STEP_BASE;
  assign err        = absdiff(win_cnt_q, target);
  assign lock_ok    = (lock_run_q == LOCK_RUNS);
  assign lock_lost  = ref_tick && (err > UNLOCK_TOL);

  assign loc_event = ext_mode && !ref_ready_q && !ctrl1_q.loc_disable;
  assign lol_event = ((state_q == ST_INT_LOCK) || (state_q == ST_EXT_LOCK)) && lock_lost;

  // Generator clock toggles on the selected tick; off state gates ticks
  assign want_ext = (state_q == ST_BYP);
  assign src_tick = (state_q != ST_OFF) && (sel_ext_q ? ext_tick : dco_tick);
  assign gen_rise = src_tick && !o_gen_clk;

  // Mode changes re-enter through the entry map so dead sources stay out
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_OFF:
        state_d = entry_state(ctrl1_q.clock_mode_field, ref_ready_q);
      ST_SCM:
        state_d = entry_state(ctrl1_q.clock_mode_field, ref_ready_q);
      ST_INT_UNLK:
        if (ctrl1_q.clock_mode_field != loop_internal_mode)
          state_d = entry_state(ctrl1_q.clock_mode_field, ref_ready_q);
        else if (lock_ok)
          state_d = ST_INT_LOCK;
      ST_INT_LOCK:
        if (ctrl1_q.clock_mode_field != loop_internal_mode)
          state_d = entry_state(ctrl1_q.clock_mode_field, ref_ready_q);
        else if (lock_lost)
          state_d = ST_INT_UNLK;
      ST_BYP:
        if (!ref_ready_q)
          state_d = ST_SCM;
        else if (ctrl1_q.clock_mode_field != loop_bypass_external_mode)
          state_d = entry_state(ctrl1_q.clock_mode_field, ref_ready_q);
      ST_EXT_UNLK:
        if (!ref_ready_q)
          state_d = ST_SCM;
        else if (ctrl1_q.clock_mode_field != loop_external_mode)
          state_d = entry_state(ctrl1_q.clock_mode_field, ref_ready_q);
        else if (lock_ok)
          state_d = ST_EXT_LOCK;
      ST_EXT_LOCK:
        if (!ref_ready_q)
          state_d = ST_SCM;
        else if (ctrl1_q.clock_mode_field != loop_external_mode)
          state_d = entry_state(ctrl1_q.clock_mode_field, ref_ready_q);
        else if (lock_lost)
          state_d = ST_EXT_UNLK;
      default:
        state_d = ST_SCM;
    endcase
    if (i_stop)
      state_d = ST_OFF;
  end

  always_comb
  begin
    rd_mux = 8'h00;
    if (i_addr == ADDR_CTRL1)
      rd_mux = ctrl1_q;
    else if (i_addr == ADDR_CTRL2)
      rd_mux = ctrl2_q;
    else if (i_addr == ADDR_STATUS)
    begin
      rd_mux[ST_LOC_BIT]   = loc_flag_q;
      rd_mux[ST_LOCK_BIT]  = o_locked;
      rd_mux[ST_LOL_BIT]   = lol_flag_q;
      rd_mux[ST_READY_BIT] = ref_ready_q;
      rd_mux[ST_REQ_BIT]   = loc_flag_q || lol_flag_q;
    end
    else if (i_addr == ADDR_FILTER)
      rd_mux = filter_q;
    else if (i_addr == ADDR_TRIM)
      rd_mux = trim_q;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl1_q        <= intcg_ctrl1_type'(CTRL1_RST);
      ctrl2_q        <= intcg_ctrl2_type'(CTRL2_RST);
      first_done_q   <= 1'b0;
      pin_reserved_q <= 1'b0;
      trim_q         <= TRIM_RST;
      o_rd_data      <= 8'h00;
    end
    else
    begin
      ctrl1_q <= ctrl1_d;
      if (wr_ctrl1 && !first_done_q)
      begin
        first_done_q   <= 1'b1;
        pin_reserved_q <= wr_ctrl1_val.clock_mode_field[1];
      end
      if (wr_ctrl2)
        ctrl2_q <= intcg_ctrl2_type'(i_wr_data);
      if (wr_trim)
        trim_q <= i_wr_data;
      o_rd_data <= i_rd ? rd_mux : 8'h00;
    end
  end

  // Filter word is the oscillator setting; only the loop and writes in self-clocked state touch it, not stop
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q    <= ST_SCM;
      filter_q   <= FILTER_RST;
      acc_q      <= 8'h00;
      win_cnt_q  <= 8'h00;
      lock_run_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      acc_q   <= acc_sum[7:0];
      if (wr_filter && (state_q == ST_SCM))
        filter_q <= i_wr_data;
      else if (ref_tick && (win_cnt_q < target) && (filter_q != 8'hFF))
        filter_q <= filter_q + 8'h01;
      else if (ref_tick && (win_cnt_q > target) && (filter_q != 8'h00))
        filter_q <= filter_q - 8'h01;
      if (ref_tick)
        win_cnt_q <= 8'h00;
      else if (dco_tick && (win_cnt_q != 8'hFF))
        win_cnt_q <= win_cnt_q + 8'h01;
      if (!loop_state)
        lock_run_q <= 3'h0;
      else if (ref_tick && (err <= LOCK_TOL) && !lock_ok)
        lock_run_q <= lock_run_q + 3'h1;
      else if (ref_tick && (err > LOCK_TOL))
        lock_run_q <= 3'h0;
    end
  end

  // External reference watchdog; ready drops if edges stop arriving
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_prev_q  <= 1'b0;
      ref_to_q    <= 9'h000;
      ref_ready_q <= 1'b0;
    end
    else
    begin
      pin_prev_q <= pin_level;
      if (ext_tick)
      begin
        ref_to_q    <= 9'h000;
        ref_ready_q <= 1'b1;
      end
      else if (ref_to_q >= REF_TIMEOUT_CYC - 9'h001)
        ref_ready_q <= 1'b0;
      else
        ref_to_q <= ref_to_q + 9'h001;
    end
  end

  // Events beat a same-cycle clear; clear is write one
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      loc_flag_q  <= 1'b0;
      lol_flag_q  <= 1'b0;
      o_reset_req <= 1'b0;
      o_irq_req   <= 1'b0;
    end
    else
    begin
      loc_flag_q  <= loc_event || (loc_flag_q && !(wr_status && i_wr_data[ST_LOC_BIT]));
      lol_flag_q  <= lol_event || (lol_flag_q && !(wr_status && i_wr_data[ST_LOL_BIT]));
      o_reset_req <= (loc_event && ctrl2_q.loc_reset_en) || (lol_event && ctrl2_q.lol_reset_en);
      o_irq_req   <= (loc_flag_q && !ctrl2_q.loc_reset_en) || (lol_flag_q && !ctrl2_q.lol_reset_en);
    end
  end

  // Source swap waits for the old tick that ends a high half, or for the off state with the clock low
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_gen_clk     <= 1'b0;
      sel_ext_q     <= 1'b0;
      o_loop_clk_en <= 1'b0;
    end
    else
    begin
      o_loop_clk_en <= dco_tick && (state_q != ST_OFF);
      if (src_tick)
        o_gen_clk <= !o_gen_clk;
      // A dead external source never ends its own half, so it is dropped at once
      if ((sel_ext_q != want_ext) &&
          (((src_tick || (state_q == ST_OFF)) && (o_gen_clk == src_tick)) || (sel_ext_q && !ref_ready_q)))
        sel_ext_q <= want_ext;
    end
  end

  intcg_pow2_div #(
    .WIDTH (7)
  ) u_bus_div (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_tick  (gen_rise),
    .i_sel   (ctrl2_q.bus_div),
    .o_pulse (o_bus_clk_en)
  );

  // Side clocks are independent of mode and of stop
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      iref_cnt_q             <= 9'h000;
      dbg_cnt_q              <= 3'h0;
      rti_cnt_q              <= 32'h0;
      o_debug_local_clock_en <= 1'b0;
      o_rti_clk_en           <= 1'b0;
    end
    else
    begin
      iref_cnt_q             <= iref_tick ? 9'h000 : iref_cnt_q + 9'h001;
      dbg_cnt_q              <= (dbg_cnt_q == 3'(DBG_DIV - 1)) ? 3'h0 : dbg_cnt_q + 3'h1;
      o_debug_local_clock_en <= (dbg_cnt_q == 3'(DBG_DIV - 1));
      rti_cnt_q              <= (rti_cnt_q == RTI_DIV - 1) ? 32'h0 : rti_cnt_q + 32'h1;
      o_rti_clk_en           <= (rti_cnt_q == RTI_DIV - 1);
    end
  end

  // Pin and oscillator controls
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_osc_out                <= 1'b0;
      o_osc_out_oe_n           <= 1'b1;
      o_osc_in_en              <= 1'b0;
      o_high_gain              <= 1'b0;
      o_range_high             <= 1'b0;
      o_fixed_frequency_enable <= 1'b0;
      o_locked                 <= 1'b0;
      o_ext_ref_ready          <= 1'b0;
    end
    else
    begin
      o_osc_out                <= !pin_level;
      o_osc_out_oe_n           <= !(pin_reserved_q && ctrl1_q.reference_type_select);
      o_osc_in_en              <= pin_reserved_q;
      o_high_gain              <= ctrl1_q.high_gain_select;
      o_range_high             <= ctrl1_q.range_high;
      o_fixed_frequency_enable <= ext_mode;
      o_locked                 <= (state_q == ST_INT_LOCK) || (state_q == ST_EXT_LOCK);
      o_ext_ref_ready          <= ref_ready_q;
    end
  end

endmodule // intcg_clock_generator
`default_nettype wire

// File: bench/intcg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module intcg_properties
  import intcg_pkg::*;
#(
  parameter int unsigned RTI_DIV = CLK_HZ / RTI_HZ
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_stop,
  input wire logic o_gen_clk,
  input wire logic o_loop_clk_en,
  input wire logic o_bus_clk_en,
  input wire logic o_debug_local_clock_en,
  input wire logic o_rti_clk_en,
  input wire logic o_fixed_frequency_enable,
  input wire logic o_locked,
  input wire logic o_ext_ref_ready,
  input wire logic o_reset_req,
  input wire logic o_osc_in_en,
  input wire logic o_osc_out_oe_n
);
  logic [15:0] rti_cnt_q;
  logic        rti_seen_q;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // The first tick after reset only arms the period check
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rti_cnt_q  <= 16'h0000;
      rti_seen_q <= 1'b0;
    end
    else
    begin
      rti_cnt_q  <= o_rti_clk_en ? 16'h0001 : rti_cnt_q + 16'h0001;
      rti_seen_q <= rti_seen_q | o_rti_clk_en;
    end
  end

  sequence s_held_stop;
    i_stop ##1 i_stop;
  endsequence

  sequence s_debug_gap;
    !o_debug_local_clock_en [*4] ##1 o_debug_local_clock_en;
  endsequence

  a_reset_self_clocked: assert property ($rose(i_nrst) |-> !o_locked && !o_fixed_frequency_enable)
    else $error("not self-clocked after reset");
  a_stop_freezes_clock: assert property (s_held_stop |=> $stable(o_gen_clk) && !o_loop_clk_en && !o_locked)
    else $error("output clock moved while stopped");
  a_bypass_needs_ready: assert property ($rose(o_fixed_frequency_enable) |-> o_ext_ref_ready)
    else $error("external source used before ready");
  a_ext_needs_pin: assert property (o_fixed_frequency_enable |-> o_osc_in_en)
    else $error("external source without reserved pin");
  a_pins_left_idle: assert property (!o_osc_in_en |-> o_osc_out_oe_n)
    else $error("oscillator output driven without claim");
  a_reset_req_pulse: assert property (o_reset_req |=> !o_reset_req)
    else $error("reset request longer than one cycle");
  a_bus_en_spacing: assert property (o_bus_clk_en |=> !o_bus_clk_en)
    else $error("bus enable on adjacent cycles");
  a_debug_period: assert property (o_debug_local_clock_en |=> s_debug_gap)
    else $error("debug clock enable period wrong");
  a_rti_period: assert property (o_rti_clk_en && rti_seen_q |-> rti_cnt_q == 16'(RTI_DIV))
    else $error("real-time tick period wrong");
endmodule // intcg_properties

bind intcg_clock_generator intcg_properties #(.RTI_DIV(RTI_DIV)) u_props (
  .i_clk, .i_nrst, .i_stop, .o_gen_clk, .o_loop_clk_en, .o_bus_clk_en, .o_debug_local_clock_en,
  .o_rti_clk_en, .o_fixed_frequency_enable, .o_locked, .o_ext_ref_ready, .o_reset_req,
  .o_osc_in_en, .o_osc_out_oe_n
);
`default_nettype wire

// File: bench/intcg_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
module intcg_ext_src #(
  parameter int unsigned HALF_NS = 200
) (
  input  wire logic i_run,
  output var  logic o_clk
);
  // Free of the system clock phase; a stopped source rests low
  initial
  begin
    o_clk = 1'b0;
    forever
    begin
      #(HALF_NS);
      o_clk = i_run ? ~o_clk : 1'b0;
    end
  end
endmodule // intcg_ext_src
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import intcg_pkg::*;
  logic              i_clk, i_nrst, i_wr, i_rd, i_stop, ext_run, osc, gclk, loop_en, bus_en;
  logic              ffe, locked, ready, rst_req, irq, pin_en, oe_n, hg, rh;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wr_data, o_rd_data;
  logic [7:0]        rexp [6] = '{CTRL1_RST, CTRL2_RST, 8'h00, FILTER_RST, TRIM_RST, 8'h00};
  int                n_errors, checks_done, cyc, n, m;

  intcg_clock_generator #(.RTI_DIV(50)) u_dut (
    .i_clk, .i_nrst, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_stop, .i_osc_in(osc),
    .o_osc_out(), .o_osc_out_oe_n(oe_n), .o_osc_in_en(pin_en), .o_high_gain(hg), .o_range_high(rh),
    .o_gen_clk(gclk), .o_loop_clk_en(loop_en), .o_bus_clk_en(bus_en), .o_debug_local_clock_en(),
    .o_rti_clk_en(), .o_fixed_frequency_enable(ffe), .o_locked(locked), .o_ext_ref_ready(ready),
    .o_reset_req(rst_req), .o_irq_req(irq)
  );
  intcg_ext_src u_src (.i_run(ext_run), .o_clk(osc));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Generous ceiling; a hung wait lands here instead of spinning forever
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rd_data;
    check(16'(d), 16'(exp));
    @(posedge i_clk);
  endtask

  task automatic wait_hi(ref logic s);
    while (s !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
    end
  endtask

  task automatic count_en(output int c);
    c = 0;
    repeat (256)
    begin
      @(posedge i_clk);
      #1 c += int'(loop_en);
    end
  endtask

  // Rises of the output clock between two bus enables, after one to align
  task automatic bus_gap(output int r);
    logic p;
    p = gclk;
    repeat (2)
    begin
      r = 0;
      do
      begin
        @(posedge i_clk);
        #1 r += int'(gclk && !p);
        p = gclk;
      end
      while (!bus_en);
    end
  endtask

  task automatic rise_gap(output int c);
    wait_hi(gclk);
    while (gclk)
      @(posedge i_clk);
    wait_hi(gclk);
    c = 0;
    while (gclk)
    begin
      @(posedge i_clk);
      #1 c++;
    end
    while (!gclk)
    begin
      @(posedge i_clk);
      #1 c++;
    end
  endtask

  task automatic do_reset;
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
  endtask

  initial
  begin
    {i_nrst, i_wr, i_rd, i_stop, ext_run, i_addr, i_wr_data} = '0;
    {n_errors, checks_done, cyc} = '0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    #1 check(16'(locked), 16'h0000);
    check(16'(ffe), 16'h0000);
    check(16'(hg), 16'h0000);
    wr(3'h5, 8'hFF);
    for (int i = 0; i < 6; i++)
      rc(3'(i), rexp[i]);
    count_en(n);
    check(16'(n), 16'(FILTER_RST));
    wr(ADDR_FILTER, 8'h80);
    count_en(n);
    check(16'(n), 16'h0080);
    for (int d = 0; d < 8; d++)
    begin
      wr(ADDR_CTRL2, 8'(d));
      bus_gap(n);
      check(16'(n), 16'(1 << d));
    end
    i_stop <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 m = int'(gclk);
    count_en(n);
    check(16'(n), 16'h0000);
    check(16'(gclk), 16'(m));
    i_stop <= 1'b0;
    rc(ADDR_FILTER, 8'h80);
    wr(ADDR_CTRL1, 8'h08);
    repeat (2) @(posedge i_clk);
    check(16'(pin_en), 16'h0000);
    wr(ADDR_CTRL1, 8'h18);
    rc(ADDR_CTRL1, 8'h08);
    wait_hi(locked);
    check(16'(ffe), 16'h0000);
    rc(ADDR_STATUS, 8'h08);
    do_reset();
    wr(ADDR_CTRL1, 8'hD0);
    repeat (50) @(posedge i_clk);
    check(16'(pin_en), 16'h0001);
    check(16'(oe_n), 16'h0001);
    check(16'(hg), 16'h0001);
    check(16'(rh), 16'h0001);
    check(16'(ffe), 16'h0000);
    ext_run <= 1'b1;
    wait_hi(ffe);
    check(16'(ready), 16'h0001);
    rise_gap(n);
    rise_gap(n);
    check(16'(n), 16'h0020);
    ext_run <= 1'b0;
    wait_hi(irq);
    repeat (2) @(posedge i_clk);
    check(16'(ffe), 16'h0000);
    rc(ADDR_STATUS, 8'h11);
    rise_gap(n);
    check(16'(n), 16'(512 / int'(FILTER_RST)));
    wr(ADDR_STATUS, 8'h10);
    #1 check(16'(irq), 16'h0000);
    wr(ADDR_CTRL2, 8'h08);
    ext_run <= 1'b1;
    wr(ADDR_CTRL1, 8'h10);
    wait_hi(ffe);
    ext_run <= 1'b0;
    wait_hi(rst_req);
    repeat (2) @(posedge i_clk);
    check(16'(irq), 16'h0000);
    check(16'(hg), 16'h0001);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
